// ### verilog/wea_consts.svh
`ifndef WEA_CONSTS_SVH
`define WEA_CONSTS_SVH

`define WEA_SAMPLE_W        8
`define WEA_ADDR_W          10
`define WEA_SWEEP_W         11
`define WEA_SWEEP_MAX       11'h7ff
`define WEA_SWEEP_DEFAULT   11'h000
`define WEA_WEIGHT_MAX      4'h8
`define WEA_CLK_MHZ         250
`define WEA_ENV_RATE_MHZ    20
`define WEA_ENV_DIV         (`WEA_CLK_MHZ / `WEA_ENV_RATE_MHZ)

`endif

// ### verilog/wea_pkg.sv
package wea_pkg;
    typedef enum logic [3:0]
    {
        WEA_MODE_SAMPLE  = 4'h1,
        WEA_MODE_AVERAGE = 4'h2,
        WEA_MODE_ENVELOPE = 4'h4,
        WEA_MODE_HELD    = 4'h8
    } wea_mode_t;

    typedef enum logic [2:0]
    {
        WEA_ST_IDLE = 3'h1,
        WEA_ST_RUN  = 3'h2,
        WEA_ST_DONE = 3'h4
    } wea_state_t;
endpackage

// ### verilog/wea_rate_div.sv
`timescale 1ns/1ns
`include "wea_consts.svh"

// Produces a one-cycle enable at the envelope sampling rate.
module wea_rate_div
#(
    parameter int DIV = `WEA_ENV_DIV
)
(
    input  wire logic core_clk,
    input  wire logic rst,
    output logic      tick
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       tick_reg;
    logic       tick_next;

    always_comb
    begin
        tick_next = 1'b0;
        cnt_next  = cnt_reg + 8'h01;
        if (cnt_reg == 8'(DIV - 1))
        begin
            cnt_next  = 8'h00;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// ### verilog/wea_top.sv
`timescale 1ns/1ns
`include "wea_consts.svh"

// Behaviour
// - Averaging moves each point toward the new sample by weight times the difference.
// - The weight is one over a power of two from 1/1 to 1/256, applied as a right shift.
// - Envelope mode records the max and min of each interval, fresh for every acquisition unless repetitive store is on.
// - Held-envelope mode keeps earlier extremes until an explicit reset.
// - Held-envelope mode is refused while acquisition runs untriggered.
// - Plain envelope mode is allowed both triggered and untriggered.
// - The sweep limit is zero for continuous or 1 to 2047, defaulting to zero.
// - Each held-envelope sweep merges its extremes into the existing record; with held_envelope_mode set in average mode it averages instead.
// - With a nonzero limit, held-envelope acquisition stops after that many sweeps and the record holds; other modes count no sweeps.
// - Envelope modes sample the input once every 12 core clocks, about 20.8 million samples per second.
// - With requests and completion reporting enabled, one service request marks the limit.
// - Repetitive store fills points at random positions and tracks which are filled.
module wea_top
#(
    parameter int SW = `WEA_SAMPLE_W,
    parameter int AW = `WEA_ADDR_W,
    parameter int CW = `WEA_SWEEP_W
)
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [3:0]       acq_mode,
    input  wire logic [3:0]       avg_weight_shift,
    input  wire logic             held_envelope_mode,
    input  wire logic             triggered,
    input  wire logic             repetitive_store,
    input  wire logic [CW-1:0]    sweep_count_limit,
    input  wire logic             service_request_enable,
    input  wire logic             opc_enable,
    input  wire logic             held_reset,
    input  wire logic             sweep_start,
    input  wire logic             sweep_end,
    input  wire logic             sample_valid,
    input  wire logic [SW-1:0]    sample_data,
    input  wire logic [AW-1:0]    sample_addr,
    output logic                  rec_we,
    output logic [AW-1:0]         rec_addr,
    output logic [SW-1:0]         rec_max,
    output logic [SW-1:0]         rec_min,
    output logic                  record_complete,
    output logic                  held_refused,
    output logic                  operation_complete_flag,
    output logic                  service_request,
    output logic [CW-1:0]         sweeps_done
);
    localparam int DEPTH = 1 << AW;

    logic [SW-1:0] max_mem [DEPTH];
    logic [SW-1:0] min_mem [DEPTH];
    logic [DEPTH-1:0] filled_reg;
    logic [DEPTH-1:0] filled_next;

    wea_pkg::wea_state_t st_reg;
    wea_pkg::wea_state_t st_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          opc_reg;
    logic          opc_next;
    logic          srq_reg;
    logic          srq_next;
    logic          refused_reg;
    logic          refused_next;
    logic          we_reg;
    logic          we_next;
    logic [AW-1:0] addr_reg;
    logic [AW-1:0] addr_next;
    logic [SW-1:0] max_reg;
    logic [SW-1:0] max_next;
    logic [SW-1:0] min_reg;
    logic [SW-1:0] min_next;
    logic          complete_reg;
    logic          complete_next;

    logic          env_tick;
    logic          held_ok;
    logic          env_mode;
    logic          held_mode;
    logic          take;
    logic [SW-1:0] old_max;
    logic [SW-1:0] old_min;

    // Arithmetic shift keeps the step signed so the average can move both ways.
    function automatic logic [SW-1:0] avg_step(input logic [SW-1:0] prev,
                                               input logic [SW-1:0] samp,
                                               input logic [3:0]    shift);
        logic signed [SW:0] diff;
        logic signed [SW:0] step;
        logic [3:0]         sh;
        begin
            sh   = (shift > `WEA_WEIGHT_MAX) ? `WEA_WEIGHT_MAX : shift;
            diff = $signed({1'b0, samp}) - $signed({1'b0, prev});
            step = diff >>> sh;
            avg_step = SW'($signed({1'b0, prev}) + step);
        end
    endfunction

    wea_rate_div u_div
    (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (env_tick)
    );

    // Either way of selecting held-envelope mode needs a triggered acquisition.
    assign held_ok   = held_mode && triggered;
    assign held_mode = (acq_mode == wea_pkg::WEA_MODE_HELD) || held_envelope_mode;
    assign env_mode  = (acq_mode == wea_pkg::WEA_MODE_ENVELOPE) || held_mode;
    assign old_max   = max_mem[sample_addr];
    assign old_min   = min_mem[sample_addr];
    // Envelope samples are decimated to the slower rate; other modes take every sample.
    assign take      = sample_valid && (st_reg == wea_pkg::WEA_ST_RUN)
                       && (!env_mode || env_tick);
    // A point counts as new on its first hit after a reset, or on its first hit of the current sweep in the modes that start fresh.

    always_comb
    begin
        st_next       = st_reg;
        cnt_next      = cnt_reg;
        opc_next      = opc_reg;
        srq_next      = 1'b0;
        refused_next  = held_mode && !triggered;
        we_next       = 1'b0;
        addr_next     = addr_reg;
        max_next      = max_reg;
        min_next      = min_reg;
        filled_next   = filled_reg;
        complete_next = &filled_reg;
        case (st_reg)
            wea_pkg::WEA_ST_IDLE:
            begin
                if (sweep_start && !(held_mode && !held_ok))
                begin
                    st_next = wea_pkg::WEA_ST_RUN;
                end
            end
            wea_pkg::WEA_ST_RUN:
            begin
                if (sweep_end)
                begin
                    st_next = wea_pkg::WEA_ST_IDLE;
                    if (held_mode)
                    begin
                        cnt_next = cnt_reg + CW'(1);
                        if (sweep_count_limit != `WEA_SWEEP_DEFAULT
                            && cnt_next >= sweep_count_limit)
                        begin
                            st_next  = wea_pkg::WEA_ST_DONE;
                            opc_next = 1'b1;
                            srq_next = service_request_enable && opc_enable;
                        end
                    end
                end
            end
            wea_pkg::WEA_ST_DONE:
            begin
                st_next = wea_pkg::WEA_ST_DONE;
            end
            default:
            begin
                st_next = wea_pkg::WEA_ST_IDLE;
            end
        endcase
        if (take)
        begin
            we_next   = 1'b1;
            addr_next = sample_addr;
            if (acq_mode == wea_pkg::WEA_MODE_AVERAGE && filled_reg[sample_addr])
            begin
                max_next = avg_step(old_max, sample_data, avg_weight_shift);
                min_next = max_next;
            end
            else if (held_mode && filled_reg[sample_addr])
            begin
                max_next = (sample_data > old_max) ? sample_data : old_max;
                min_next = (sample_data < old_min) ? sample_data : old_min;
            end
            else if (env_mode && filled_reg[sample_addr])
            begin
                max_next = (sample_data > old_max) ? sample_data : old_max;
                min_next = (sample_data < old_min) ? sample_data : old_min;
            end
            else
            begin
                max_next = sample_data;
                min_next = sample_data;
            end
            filled_next[sample_addr] = 1'b1;
        end
        // Averaging, held and repetitive fills build on earlier sweeps; the rest start fresh.
        if (sweep_start && st_reg == wea_pkg::WEA_ST_IDLE && !held_mode
            && acq_mode != wea_pkg::WEA_MODE_AVERAGE && !repetitive_store)
        begin
            filled_next = '0;
        end
        if (held_reset)
        begin
            filled_next = '0;
            cnt_next    = '0;
            opc_next    = 1'b0;
            st_next     = wea_pkg::WEA_ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg       <= wea_pkg::WEA_ST_IDLE;
            cnt_reg      <= '0;
            opc_reg      <= 1'b0;
            srq_reg      <= 1'b0;
            refused_reg  <= 1'b0;
            we_reg       <= 1'b0;
            addr_reg     <= '0;
            max_reg      <= '0;
            min_reg      <= '0;
            filled_reg   <= '0;
            complete_reg <= 1'b0;
        end
        else
        begin
            st_reg       <= st_next;
            cnt_reg      <= cnt_next;
            opc_reg      <= opc_next;
            srq_reg      <= srq_next;
            refused_reg  <= refused_next;
            we_reg       <= we_next;
            addr_reg     <= addr_next;
            max_reg      <= max_next;
            min_reg      <= min_next;
            filled_reg   <= filled_next;
            complete_reg <= complete_next;
        end
    end

    // Record arrays carry no reset; the filled map decides whether a point is valid.
    always_ff @(posedge core_clk)
    begin
        if (take)
        begin
            max_mem[sample_addr] <= max_next;
            min_mem[sample_addr] <= min_next;
        end
    end

    assign rec_we                  = we_reg;
    assign rec_addr                = addr_reg;
    assign rec_max                 = max_reg;
    assign rec_min                 = min_reg;
    assign record_complete         = complete_reg;
    assign held_refused            = refused_reg;
    assign operation_complete_flag = opc_reg;
    assign service_request         = srq_reg;
    assign sweeps_done             = cnt_reg;
endmodule

// ### dv/wea_top_checker.sv
`timescale 1ns/1ns
module wea_top_checker
#(
    parameter int SW = 8,
    parameter int AW = 10,
    parameter int CW = 11
)
(
    input wire logic          core_clk,
    input wire logic          rst,
    input wire logic [3:0]    acq_mode,
    input wire logic          held_envelope_mode,
    input wire logic          triggered,
    input wire logic [CW-1:0] sweep_count_limit,
    input wire logic          service_request_enable,
    input wire logic          opc_enable,
    input wire logic          held_reset,
    input wire logic          sample_valid,
    input wire logic [AW-1:0] sample_addr,
    input wire logic          rec_we,
    input wire logic [AW-1:0] rec_addr,
    input wire logic [SW-1:0] rec_max,
    input wire logic [SW-1:0] rec_min,
    input wire logic          held_refused,
    input wire logic          operation_complete_flag,
    input wire logic          service_request,
    input wire logic [CW-1:0] sweeps_done
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire held = acq_mode == 4'h8 || held_envelope_mode;
    wire env  = acq_mode == 4'h4 || held;

    AST_WE_CAUSE: assert property (rec_we |-> $past(sample_valid) && rec_addr == $past(sample_addr))
        else $error("write without a taken sample");
    AST_AVG_PAIR: assert property (rec_we && acq_mode == 4'h2 && !held |-> rec_max == rec_min)
        else $error("average write differs between max and min");
    AST_ENV_ORDER: assert property (rec_we && env |-> rec_max >= rec_min)
        else $error("envelope max below min");
    // Twelve core cycles per envelope tick, so eleven quiet cycles follow each write.
    AST_ENV_RATE: assert property (rec_we && env |=> !rec_we [*8] ##1 !rec_we [*3])
        else $error("envelope writes too close");
    AST_REFUSE: assert property (held && !triggered |=> held_refused)
        else $error("held mode accepted untriggered");
    AST_ENV_OK: assert property (acq_mode == 4'h4 && !held_envelope_mode |=> !held_refused)
        else $error("plain envelope refused");
    AST_SRQ: assert property (service_request |-> operation_complete_flag &&
        service_request_enable && opc_enable ##1 !service_request)
        else $error("bad service request");
    AST_OPC_HOLD: assert property (operation_complete_flag && !held_reset |=> operation_complete_flag)
        else $error("completion flag dropped");
    AST_FROZEN: assert property (operation_complete_flag && $past(operation_complete_flag) |-> !rec_we)
        else $error("write after completion");
    AST_LIMIT: assert property ($rose(operation_complete_flag) |->
        sweeps_done == sweep_count_limit && sweep_count_limit != 0)
        else $error("completion at wrong sweep count");
    AST_CLEAR: assert property (held_reset |=> sweeps_done == 0 && !operation_complete_flag)
        else $error("held reset did not clear");
    cover property (service_request);
    cover property (rec_we && acq_mode == 4'h8);
    cover property (held_refused);
endmodule

bind wea_top wea_top_checker #(.SW(SW), .AW(AW), .CW(CW)) u_chk
(
    .core_clk, .rst, .acq_mode, .held_envelope_mode, .triggered, .sweep_count_limit,
    .service_request_enable, .opc_enable, .held_reset, .sample_valid, .sample_addr, .rec_we,
    .rec_addr, .rec_max, .rec_min, .held_refused, .operation_complete_flag, .service_request,
    .sweeps_done
);

// ### dv/wea_src.sv
`timescale 1ns/1ns
// Sampler model; released lines are inverted so stale data is never mistaken for a sample.
module wea_src
(
    input  wire logic  core_clk,
    output logic       sweep_start,
    output logic       sweep_end,
    output logic       sample_valid,
    output logic [7:0] sample_data,
    output logic [3:0] sample_addr
);
    initial {sweep_start, sweep_end, sample_valid, sample_data, sample_addr} = '0;
    task automatic sweep(input int n, input bit rnd);
        @(posedge core_clk) #1 sweep_start = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge core_clk) #1 sweep_start = 1'b0;
            sample_valid = 1'b1;
            sample_data = 8'($urandom);
            sample_addr = rnd ? 4'($urandom) : 4'(i);
        end
        @(posedge core_clk) #1 sample_valid = 1'b0;
        sample_data = ~sample_data;
        sample_addr = ~sample_addr;
        sweep_end = 1'b1;
        @(posedge core_clk) #1 sweep_end = 1'b0;
    endtask
endmodule

// ### dv/waveform_envelope_average_tb_top.sv
`timescale 1ns/1ns
module waveform_envelope_average_tb_top;
    logic core_clk = 1'b0, rst = 1'b1, held_reset = 1'b0;
    logic [3:0] acq_mode = 4'h2, avg_weight_shift = 4'h0, sample_addr, rec_addr;
    logic held_envelope_mode = 1'b0, triggered = 1'b1, repetitive_store = 1'b0;
    logic [10:0] sweep_count_limit = 11'h000, sweeps_done;
    logic service_request_enable = 1'b1, opc_enable = 1'b1;
    logic sweep_start, sweep_end, sample_valid, rec_we, record_complete, held_refused;
    logic operation_complete_flag, service_request;
    logic [7:0] sample_data, rec_max, rec_min;
    int fails = 0, n_compared = 0, cyc = 0, srq_n = 0, wr_n = 0, nf = 0, x;
    int avg [16], hmax [16], hmin [16], q [$];
    bit filled [16];
    bit avg_on = 1'b0, rep_on = 1'b0;

    always #2 core_clk = ~core_clk;
    wea_src u_src (.core_clk, .sweep_start, .sweep_end, .sample_valid, .sample_data, .sample_addr);
    wea_top #(.AW(4)) u_dut (.core_clk, .rst, .acq_mode, .avg_weight_shift, .held_envelope_mode,
        .triggered, .repetitive_store, .sweep_count_limit, .service_request_enable, .opc_enable,
        .held_reset, .sweep_start, .sweep_end, .sample_valid, .sample_data, .sample_addr, .rec_we,
        .rec_addr, .rec_max, .rec_min, .record_complete, .held_refused, .operation_complete_flag,
        .service_request, .sweeps_done);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // The model forgets extremes and fill state together with the design.
    task automatic pulse_reset;
        held_reset = 1'b1;
        hmax = '{default: 0};
        hmin = '{default: 255};
        filled = '{default: 1'b0};
        nf = 0;
        wait_cyc(1);
        held_reset = 1'b0;
    endtask

    always @(posedge core_clk)
    begin
        int e;
        cyc++;
        if (cyc > 20000)
        begin
            fails++;
            close_out();
        end
        wr_n += rec_we;
        srq_n += service_request;
        if (avg_on && sample_valid)
        begin
            e = int'(sample_data);
            if (filled[sample_addr])
                e = avg[sample_addr] + ((e - avg[sample_addr]) >>> avg_weight_shift);
            avg[sample_addr] = e;
            filled[sample_addr] = 1'b1;
            q.push_back(sample_addr * 256 + e);
        end
        if (rep_on && sample_valid && !filled[sample_addr])
        begin
            filled[sample_addr] = 1'b1;
            nf++;
        end
        if (rec_we && avg_on)
        begin
            x = q.size() ? q.pop_front() : -1;
            check({rec_addr, rec_max, rec_min}, {x[11:0], x[7:0]});
        end
        if (rec_we && acq_mode == 4'h4)
            check(rec_max, rec_min);
        if (rec_we && acq_mode == 4'h8)
        begin
            check(rec_max >= hmax[rec_addr] && rec_min <= hmin[rec_addr], 1);
            hmax[rec_addr] = rec_max;
            hmin[rec_addr] = rec_min;
        end
    end

    initial
    begin
        void'($urandom(35));
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        check({rec_we, record_complete, held_refused, operation_complete_flag, sweeps_done}, 0);
        avg_on = 1'b1;
        for (int w = 0; w <= 8; w++)
        begin
            avg_weight_shift = 4'(w);
            u_src.sweep(16, 1'b0);
        end
        wait_cyc(3);
        avg_on = 1'b0;
        check(q.size(), 0);
        acq_mode = 4'h1;
        repetitive_store = 1'b1;
        pulse_reset();
        rep_on = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            u_src.sweep(k == 3 ? 16 : 6, k != 3);
            wait_cyc(2);
            check(record_complete, nf == 16);
        end
        rep_on = 1'b0;
        repetitive_store = 1'b0;
        acq_mode = 4'h8;
        triggered = 1'b0;
        u_src.sweep(4, 1'b0);
        check({held_refused, sweeps_done}, 12'h800);
        acq_mode = 4'h4;
        wr_n = 0;
        u_src.sweep(40, 1'b0);
        check({held_refused, wr_n > 0}, 2'h1);
        acq_mode = 4'h8;
        triggered = 1'b1;
        sweep_count_limit = 11'h002;
        pulse_reset();
        repeat (2) u_src.sweep(40, 1'b0);
        wait_cyc(2);
        check({sweeps_done, operation_complete_flag, 4'(srq_n)}, {11'h002, 1'b1, 4'h1});
        wr_n = 0;
        u_src.sweep(40, 1'b0);
        check({sweeps_done, 4'(wr_n)}, {11'h002, 4'h0});
        pulse_reset();
        sweep_count_limit = 11'h000;
        check({sweeps_done, operation_complete_flag}, 12'h000);
        repeat (3) u_src.sweep(40, 1'b0);
        wait_cyc(2);
        check({sweeps_done, operation_complete_flag, 4'(srq_n)}, {11'h003, 1'b0, 4'h1});
        close_out();
    end
endmodule
